// >>> rtl/pbbs_pkg.sv
// constants and types shared by the reset and boot sequencer
package pbbs_pkg;

  // clock and timing
  localparam int  CLK_KHZ       = 100_000;
  localparam int  REL_DELAY_MS  = 1;
  localparam int  REL_DELAY_CYC = REL_DELAY_MS * CLK_KHZ;
  localparam real BOOT_TIME_MS  = 9.5;
  localparam int  BOOT_CYC      = int'(BOOT_TIME_MS * CLK_KHZ);
  localparam int  CNT_W         = 20;

  // boot rom and program flash layout
  localparam int           ROM_WORDS   = 1024;
  localparam int           ROM_AW      = 10;
  localparam int           BANK_AW     = 13;
  localparam int           FLASH_AW    = 14;
  localparam int           EXEC_AW     = 17;
  localparam logic [BANK_AW-1:0]  SIG_WORD    = 13'h1FFF;
  localparam logic [31:0]         ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [EXEC_AW-1:0]  BANK0_BASE  = 17'h00000;
  localparam logic [EXEC_AW-1:0]  BANK1_BASE  = 17'h08000;
  localparam logic [EXEC_AW-1:0]  ROM_BASE    = 17'h10000;
  localparam logic [EXEC_AW-1:0]  ALT_OFFSET  = 17'h00100;

  // sequencer states
  typedef enum logic [5:0] {
    ST_OFF       = 6'h01,
    ST_DELAY     = 6'h02,
    ST_CHECK     = 6'h04,
    ST_BOOT_WAIT = 6'h08,
    ST_WAIT_DL   = 6'h10,
    ST_EXEC      = 6'h20
  } pbbs_state_t;

  // supply comparator outputs
  typedef struct packed {
    logic power_good_threshold;  // high: above the power-good level
    logic power_bad_threshold;   // high: below the power-bad level
    logic brownout_reset_event;  // high: at or below the brown-out level
  } pbbs_supply_t;

  localparam pbbs_supply_t SUPPLY_RST = 3'h0;

  // program flash signature read
  typedef struct packed {
    logic                req;
    logic [FLASH_AW-1:0] addr;
  } pbbs_flash_rd_t;

endpackage

// >>> rtl/pbbs_sync2.sv
// two-stage synchroniser with asynchronous reset and clock enable
`timescale 1ns/1ps
module pbbs_sync2 #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         en_in,
  // data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = en_in ? d_in : stage1;
    next_q      = en_in ? stage1 : q_out;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage1 <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      stage1 <= next_stage1;
      q_out  <= next_q;
    end
  end

endmodule // pbbs_sync2

// >>> rtl/pbbs_sequencer.sv
// power-on / brown-out reset sequencer and boot steering
`timescale 1ns/1ps
// Functional notes
// - reset released only once supply is above power-good level
// - power-good crossing is the point power counts as valid
// - supply below power-bad level forces the device back into reset
// - internal reset low holds all logic; release only when it rises
// - external reset pin low resets the sequencer like internal reset low, but keeps the brown-out flag
// - fixed release delay from power-good to internal reset release
// - brown-out level sets a status flag software can read
// - brown-out also raises an interrupt when enabled
// - after release boot rom (1024 x 32) runs and checks flash image
// - valid image: execution passes to the main flash program
// - no valid image: stay in boot code awaiting bus download
// - alternative boot routine in flash may replace built-in start-up
// - execution may be steered to either of two 32 kB flash banks
// - release delay about 1 ms after power good or pin release
// - execution from flash starts about 9.5 ms after release
module pbbs_sequencer
  import pbbs_pkg::*;
#(
  parameter int REL_CYC  = REL_DELAY_CYC,
  parameter int BOOT_LEN = BOOT_CYC
) (
  // clock, reset, enable
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                clk_en_in,
  // external reset pin and supply comparators
  input  wire logic                ext_reset_n_in,
  input  wire pbbs_supply_t        supply_in,
  // brown-out control
  input  wire logic                brownout_clr_in,
  input  wire logic                brownout_irq_en_in,
  // boot options
  input  wire logic                bank_sel_in,
  input  wire logic                alt_boot_in,
  input  wire logic                download_done_in,
  // flash signature read
  input  wire logic                flash_ack_in,
  input  wire logic [31:0]         flash_data_in,
  output pbbs_flash_rd_t           flash_rd_out,
  // reset and execution status
  output logic                     sys_rst_n_out,
  output logic                     rom_active_out,
  output logic [ROM_AW-1:0]        rom_pc_out,
  output logic                     dl_wait_out,
  output logic                     exec_start_out,
  output logic [EXEC_AW-1:0]       exec_addr_out,
  // brown-out status
  output logic                     brownout_flag_out,
  output logic                     brownout_irq_out
);

  localparam logic [CNT_W-1:0] REL_LAST  = CNT_W'(REL_CYC - 1);
  localparam logic [CNT_W-1:0] BOOT_LAST = CNT_W'(BOOT_LEN - 1);
  localparam logic [ROM_AW-1:0] ROM_LAST = ROM_AW'(ROM_WORDS - 1);

  function automatic logic [FLASH_AW-1:0] sig_addr(input logic bank);
    sig_addr = {bank, SIG_WORD};
  endfunction

  function automatic logic [EXEC_AW-1:0] entry_addr(input logic bank,
                                                    input logic alt);
    logic [EXEC_AW-1:0] base;
    base = bank ? BANK1_BASE : BANK0_BASE;
    entry_addr = alt ? base + ALT_OFFSET : base;
  endfunction

  function automatic logic is_rom_state(input pbbs_state_t s);
    is_rom_state = (s == ST_CHECK) || (s == ST_BOOT_WAIT) ||
                   (s == ST_WAIT_DL);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset combination and input synchronisers
  logic         comb_rst_n;
  logic         core_rst_n;
  pbbs_supply_t supply_s;

  assign comb_rst_n = rst_n_in & ext_reset_n_in;

  pbbs_sync2 #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
    .clk_in    (core_clk_in),
    .arst_n_in (comb_rst_n),
    .en_in     (clk_en_in),
    .d_in      (1'b1),
    .q_out     (core_rst_n)
  );

  pbbs_sync2 #(.W(3), .RST_VAL(SUPPLY_RST)) u_supply_sync (
    .clk_in    (core_clk_in),
    .arst_n_in (rst_n_in),
    .en_in     (clk_en_in),
    .d_in      (supply_in),
    .q_out     (supply_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // reset and boot state machine
  pbbs_state_t        state;
  pbbs_state_t        next_state;
  logic [CNT_W-1:0]   dly_cnt;
  logic [CNT_W-1:0]   next_dly_cnt;
  logic [CNT_W-1:0]   boot_cnt;
  logic [CNT_W-1:0]   next_boot_cnt;
  logic [ROM_AW-1:0]  next_rom_pc;
  pbbs_flash_rd_t     next_flash_rd;
  logic               next_sys_rst_n;
  logic               next_exec_start;
  logic [EXEC_AW-1:0] next_exec_addr;
  logic               image_ok;
  logic               in_rom;
  logic               next_rom_active;
  logic               next_dl_wait;

  assign image_ok = (flash_data_in != ERASED_WORD);
  assign in_rom   = is_rom_state(state);

  always_comb begin
    next_state      = state;
    next_dly_cnt    = dly_cnt;
    next_boot_cnt   = boot_cnt;
    next_rom_pc     = rom_pc_out;
    next_flash_rd   = flash_rd_out;
    next_exec_start = 1'b0;
    next_exec_addr  = exec_addr_out;
    if (in_rom) begin
      next_rom_pc = (rom_pc_out == ROM_LAST) ? '0 : rom_pc_out + 1'b1;
      if (boot_cnt != BOOT_LAST)
        next_boot_cnt = boot_cnt + 1'b1;
    end
    case (state)
      ST_OFF: begin
        next_dly_cnt = '0;
        if (supply_s.power_good_threshold &&
            !supply_s.power_bad_threshold)
          next_state = ST_DELAY;
      end
      ST_DELAY: begin
        next_dly_cnt = dly_cnt + 1'b1;
        if (dly_cnt == REL_LAST) begin
          next_state     = ST_CHECK;
          next_boot_cnt  = '0;
          next_rom_pc    = '0;
          next_exec_addr = ROM_BASE;
          next_flash_rd  = '{req: 1'b1, addr: sig_addr(bank_sel_in)};
        end
      end
      ST_CHECK: begin
        if (flash_ack_in) begin
          next_flash_rd.req = 1'b0;
          next_state = image_ok ? ST_BOOT_WAIT : ST_WAIT_DL;
        end
      end
      ST_BOOT_WAIT: begin
        if (boot_cnt == BOOT_LAST) begin
          next_state      = ST_EXEC;
          next_exec_start = 1'b1;
          next_exec_addr  = entry_addr(bank_sel_in, alt_boot_in);
        end
      end
      ST_WAIT_DL: begin
        if (download_done_in) begin
          next_state    = ST_CHECK;
          next_flash_rd = '{req: 1'b1, addr: sig_addr(bank_sel_in)};
        end
      end
      ST_EXEC: ;
      default: next_state = ST_OFF;
    endcase
    if (supply_s.power_bad_threshold) begin
      next_state        = ST_OFF;
      next_flash_rd.req = 1'b0;
      next_exec_start   = 1'b0;
      next_exec_addr    = exec_addr_out;
    end
    next_sys_rst_n = (next_state != ST_OFF) && (next_state != ST_DELAY);
    next_rom_active = is_rom_state(next_state);
    next_dl_wait    = (next_state == ST_WAIT_DL);
  end

  always_ff @(posedge core_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state          <= ST_OFF;
      dly_cnt        <= '0;
      boot_cnt       <= '0;
      rom_pc_out     <= '0;
      flash_rd_out   <= '0;
      sys_rst_n_out  <= 1'b0;
      exec_start_out <= 1'b0;
      exec_addr_out  <= ROM_BASE;
      rom_active_out <= 1'b0;
      dl_wait_out    <= 1'b0;
    end else if (clk_en_in) begin
      state          <= next_state;
      dly_cnt        <= next_dly_cnt;
      boot_cnt       <= next_boot_cnt;
      rom_pc_out     <= next_rom_pc;
      flash_rd_out   <= next_flash_rd;
      sys_rst_n_out  <= next_sys_rst_n;
      exec_start_out <= next_exec_start;
      exec_addr_out  <= next_exec_addr;
      rom_active_out <= next_rom_active;
      dl_wait_out    <= next_dl_wait;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // brown-out flag and interrupt, kept across the device reset
  logic bo_prev;
  logic bo_rise;
  logic next_bo_flag;
  logic next_bo_irq;

  assign bo_rise = supply_s.brownout_reset_event && !bo_prev;

  always_comb begin
    next_bo_flag = brownout_flag_out;
    if (brownout_clr_in)
      next_bo_flag = 1'b0;
    if (bo_rise)
      next_bo_flag = 1'b1;
    next_bo_irq = next_bo_flag && brownout_irq_en_in;
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bo_prev           <= 1'b0;
      brownout_flag_out <= 1'b0;
      brownout_irq_out  <= 1'b0;
    end else if (clk_en_in) begin
      bo_prev           <= supply_s.brownout_reset_event;
      brownout_flag_out <= next_bo_flag;
      brownout_irq_out  <= next_bo_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  release_after_good_a: assert property (
    $rose(sys_rst_n_out) |-> $past(state) == ST_DELAY &&
      $past(dly_cnt) == REL_LAST)
    else $error("reset released without completed power-good delay");

  delay_holds_reset_a: assert property (
    (state == ST_DELAY || state == ST_OFF) |-> !sys_rst_n_out)
    else $error("internal reset high during release delay");

  good_starts_delay_a: assert property (
    (state == ST_OFF && clk_en_in && core_rst_n &&
     supply_s.power_good_threshold && !supply_s.power_bad_threshold)
      |=> state == ST_DELAY || !core_rst_n)
    else $error("power-good crossing did not start release delay");

  power_bad_reset_a: assert property (
    (clk_en_in && supply_s.power_bad_threshold) |=> !sys_rst_n_out)
    else $error("power-bad level did not force reset");

  pin_reset_a: assert property (
    !ext_reset_n_in |=> !sys_rst_n_out)
    else $error("reset pin low did not hold device in reset");

  brownout_set_a: assert property (
    (clk_en_in && bo_rise) |=> brownout_flag_out)
    else $error("brown-out event did not set flag");

  brownout_sticky_a: assert property (
    (brownout_flag_out && !(clk_en_in && brownout_clr_in))
      |=> brownout_flag_out)
    else $error("brown-out flag dropped without clear");

  brownout_irq_a: assert property (
    brownout_irq_out |-> brownout_flag_out && $past(brownout_irq_en_in))
    else $error("brown-out interrupt without flag or enable");

  exec_timing_a: assert property (
    exec_start_out |-> $past(boot_cnt) == BOOT_LAST &&
      $past(state) == ST_BOOT_WAIT)
    else $error("flash execution started at wrong time");

  no_image_wait_a: assert property (
    (state == ST_CHECK && clk_en_in && flash_ack_in && !image_ok &&
     !supply_s.power_bad_threshold && core_rst_n)
      |=> state == ST_WAIT_DL && dl_wait_out || !core_rst_n)
    else $error("missing image did not wait for download");

  exec_target_a: assert property (
    exec_start_out |-> exec_addr_out ==
      entry_addr($past(bank_sel_in), $past(alt_boot_in)))
    else $error("execution entry address wrong");

  rom_step_a: assert property (
    (rom_active_out && clk_en_in) |=>
      rom_pc_out == ROM_AW'($past(rom_pc_out) + 1'b1) || !core_rst_n)
    else $error("boot rom word address did not step");

  download_recheck_a: assert property (
    (state == ST_WAIT_DL && clk_en_in && download_done_in &&
     !supply_s.power_bad_threshold && core_rst_n)
      |=> (state == ST_CHECK && flash_rd_out.req) || !core_rst_n)
    else $error("download did not restart the image check");

  irq_mask_a: assert property (
    (clk_en_in && !brownout_irq_en_in) |=> !brownout_irq_out)
    else $error("brown-out interrupt raised while disabled");

  release_c: cover property ($rose(sys_rst_n_out));
  exec_c: cover property (exec_start_out);
  download_c: cover property ($rose(dl_wait_out));
  irq_c: cover property ($rose(brownout_irq_out));

endmodule // pbbs_sequencer

// >>> sim/pbbs_far_model.sv
// supply comparators, reset pin and flash signature responder
`timescale 1ns/1ps
module pbbs_far_model
  import pbbs_pkg::*;
#(
  parameter logic [15:0] GOOD_MV  = 16'h0BB8,
  parameter logic [15:0] BROWN_MV = 16'h0B54,
  parameter logic [15:0] BAD_MV   = 16'h0A8C,
  parameter int          ACK_DLY  = 3
) (
  // clock
  input  wire logic           core_clk_in,
  // bench controls
  input  wire logic [15:0]    supply_mv_in,
  input  wire logic           pin_low_in,
  input  wire logic           image_ok_in,
  input  wire pbbs_flash_rd_t flash_rd_in,
  // toward the sequencer
  output pbbs_supply_t        supply_out,
  output logic                ext_reset_n_out,
  output logic                flash_ack_out,
  output logic [31:0]         flash_data_out
);
  int wait_cnt;

  assign supply_out = '{power_good_threshold: supply_mv_in > GOOD_MV,
                        power_bad_threshold:  supply_mv_in < BAD_MV,
                        brownout_reset_event: supply_mv_in <= BROWN_MV};
  assign ext_reset_n_out = !pin_low_in;

  initial begin
    flash_ack_out  = 1'b0;
    flash_data_out = 32'h0000_0000;
    wait_cnt       = 0;
  end

  // data line is junk outside the acknowledge cycle
  always @(negedge core_clk_in) begin
    flash_ack_out  <= 1'b0;
    flash_data_out <= ~flash_data_out;
    if (flash_rd_in.req && !flash_ack_out) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt == ACK_DLY) begin
        flash_ack_out  <= 1'b1;
        flash_data_out <= image_ok_in ? 32'h0000_A5A5 : ERASED_WORD;
        wait_cnt       <= 0;
      end
    end
  end
endmodule // pbbs_far_model

// >>> sim/test_por_bor_boot_sequencer.sv
// self-checking bench for the reset and boot sequencer
`timescale 1ns/1ps
module test_por_bor_boot_sequencer;
  import pbbs_pkg::*;
  localparam int RC = 8;
  localparam int BL = 40;
  typedef struct {logic b; logic a; logic ok; logic [16:0] ea;} pbbs_row_t;
  pbbs_row_t rows [5] = '{'{0,0,1,17'h00000}, '{1,0,1,17'h08000},
    '{0,1,1,17'h00100}, '{1,1,1,17'h08100}, '{0,0,0,17'h00000}};
  logic clk = 0, rst_n = 0, clr = 0, irq_en = 0, bsel = 0, alt = 0, dl = 0;
  logic pin_low = 0, img = 1, ack, rst_out, rom, dlw, xs, flag, irq;
  logic en = 1;
  logic [15:0] mv = 16'h0000;
  logic [31:0] fdat;
  logic [9:0] pc;
  logic [16:0] xa;
  pbbs_supply_t sup;
  pbbs_flash_rd_t frd;
  logic ext_n;
  int n_errors = 0, n_checks = 0, cycles = 0, c;

  pbbs_sequencer #(.REL_CYC(RC), .BOOT_LEN(BL)) dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(en),
    .ext_reset_n_in(ext_n), .supply_in(sup), .brownout_clr_in(clr),
    .brownout_irq_en_in(irq_en), .bank_sel_in(bsel), .alt_boot_in(alt),
    .download_done_in(dl), .flash_ack_in(ack), .flash_data_in(fdat),
    .flash_rd_out(frd), .sys_rst_n_out(rst_out), .rom_active_out(rom),
    .rom_pc_out(pc), .dl_wait_out(dlw), .exec_start_out(xs),
    .exec_addr_out(xa), .brownout_flag_out(flag), .brownout_irq_out(irq));

  pbbs_far_model far (.core_clk_in(clk), .supply_mv_in(mv),
    .pin_low_in(pin_low), .image_ok_in(img), .flash_rd_in(frd),
    .supply_out(sup), .ext_reset_n_out(ext_n), .flash_ack_out(ack),
    .flash_data_out(fdat));

  initial begin
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // counts falling edges until the internal reset is released
  task automatic wait_rel(output int n);
    n = 0;
    while (rst_out !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wait_end(output int n);
    n = 0;
    while (xs !== 1'b1 && dlw !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk);
    chk(rst_out, 0);
    chk(xa, ROM_BASE);
    chk(flag, 0);
    rst_n = 1;
    foreach (rows[i]) begin
      mv = 16'h0000;
      repeat (4) @(negedge clk);
      chk(rst_out, 0);
      bsel = rows[i].b;
      alt = rows[i].a;
      img = rows[i].ok;
      mv = 16'h0CE4;
      wait_rel(c);
      chk(c >= RC + 1 && c <= RC + 6, 1);
      chk(rom, 1);
      chk(pc, 0);
      chk({frd.req, frd.addr}, {1'b1, rows[i].b, SIG_WORD});
      wait_end(c);
      chk(dlw, !rows[i].ok);
      if (rows[i].ok) begin
        chk(c >= BL - 4 && c <= BL + 2, 1);
        chk(xa, rows[i].ea);
        @(negedge clk);
        chk({xs, rom}, 2'b00);
      end
    end
    // waiting in boot code: rom address wraps after a full rom
    c = pc;
    repeat (ROM_WORDS) @(negedge clk);
    chk(pc, c);
    chk(dlw, 1);
    // download fills the image, check is run again
    img = 1;
    dl = 1;
    @(negedge clk);
    dl = 0;
    wait_end(c);
    repeat (2) @(negedge clk);
    chk(xa, BANK0_BASE);
    // level between bad and good: never released
    mv = 16'h0000;
    repeat (4) @(negedge clk);
    mv = 16'h0AF0;
    repeat (30) @(negedge clk);
    chk(rst_out, 0);
    mv = 16'h0CE4;
    wait_rel(c);
    clr = 1;
    @(negedge clk);
    clr = 0;
    @(negedge clk);
    chk(flag, 0);
    // brown-out without power-bad, interrupt first masked
    mv = 16'h0B22;
    repeat (4) @(negedge clk);
    chk({flag, irq, rst_out}, 3'b101);
    irq_en = 1;
    repeat (2) @(negedge clk);
    chk(irq, 1);
    mv = 16'h0A00;
    repeat (4) @(negedge clk);
    chk({rst_out, flag}, 2'b01);
    clr = 1;
    @(negedge clk);
    clr = 0;
    repeat (2) @(negedge clk);
    chk({flag, irq}, 2'b00);
    // external pin holds reset like the internal one
    mv = 16'h0CE4;
    wait_rel(c);
    pin_low = 1;
    repeat (2) @(negedge clk);
    chk({rst_out, rom}, 2'b00);
    pin_low = 0;
    wait_rel(c);
    chk(c >= RC + 1 && c <= RC + 6, 1);
    // clock enable low freezes the boot rom address
    en = 0;
    c = pc;
    repeat (5) @(negedge clk);
    chk(pc, c);
    chk(rst_out, 1);
    en = 1;
    @(negedge clk);
    chk(pc, c + 1);
    results();
  end
endmodule // test_por_bor_boot_sequencer
